/* shared/uscg_pkg.sv */
/*
 Constants, types and register layout of the serial transceiver clock front end.
 Assumes an 8-bit register port with a 3-bit word address.
*/
package uscg_pkg;
   // register addresses
   localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
   localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
   localparam logic [2:0] ADDR_CTRL_A = 3'h2;
   localparam logic [2:0] ADDR_CTRL_B = 3'h3;
   localparam logic [2:0] ADDR_CTRL_C = 3'h4;
   localparam logic [2:0] ADDR_DATA = 3'h5;
   localparam logic [2:0] ADDR_PIN_CTRL = 3'h6;
   // field positions
   localparam int A_RX_DONE = 7;
   localparam int A_TX_EMPTY = 5;
   localparam int A_FRAME_ERR = 4;
   localparam int A_OVERRUN = 3;
   localparam int A_PAR_ERR = 2;
   localparam int A_DOUBLE = 1;
   localparam int B_RX_EN = 4;
   localparam int B_TX_EN = 3;
   localparam int C_SYNC = 6;
   localparam int C_PAR_EN = 5;
   localparam int C_PAR_ODD = 4;
   localparam int C_TWO_STOP = 3;
   localparam int C_POL = 0;
   localparam int P_POWER_RED = 1;
   localparam int P_XCK_DIR = 0;
   // reset values
   localparam logic [11:0] DIV_RESET = 12'h000;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // sequencer last states and mid-bit sample points
   localparam logic [3:0] PH_LAST_NORMAL = 4'hf;
   localparam logic [3:0] PH_LAST_DOUBLE = 4'h7;
   localparam logic [3:0] PH_LAST_SYNC = 4'h1;
   localparam logic [3:0] PH_MID_NORMAL = 4'h7;
   localparam logic [3:0] PH_MID_DOUBLE = 4'h3;
   // frame geometry
   localparam logic [3:0] TX_BITS_BASE = 4'h9;
   localparam logic [3:0] RX_STOP_BASE = 4'h9;
   localparam logic [1:0] FIFO_FULL = 2'h2;

   typedef struct packed {
      logic fe;
      logic pe;
      logic [7:0] data;
   } uscg_rx_s;

   typedef enum logic [0:0] {
      RX_IDLE = 1'b0,
      RX_BUSY = 1'b1
   } uscg_rx_e;
endpackage : uscg_pkg

/* hdl/uscg_top.sv */
/*
 Serial transceiver with baud generator, async/sync clocking, tx buffer
 and two-level rx buffer. Assumes CLK at 100 MHz, pins from other domains.
*/
// Chosen here: the address-and-strobe port and the register offsets.
// What this block does
// - Four clock modes: async normal, async double, sync master, sync slave.
// - In sync mode, clock pin direction picks master (out) or slave (in).
// - Transfer clock pin used only in synchronous mode.
// - Baud counter reloads divisor at zero and on divisor low byte write.
// - One baud tick each time the counter reaches zero.
// - Transmitter divides baud tick by 16, 8 or 2 per mode.
// - Receiver sequencer uses 16, 8 or 2 states from mode settings.
// - Bit rate is clock over 16, 8 or 2 times divisor plus one.
// - Divisor is twelve bits in high and low byte registers.
// - Double speed bit only affects asynchronous timing.
// - Double speed receiver runs 8 sequencer states per bit, not 16.
// - Slave clock passes synchroniser then edge detector before use.
// - Sync input sampled on the edge opposite to output change.
// - Polarity 0: change on rise, sample on fall; 1: reversed.
// - Block disabled unless power reduction bit is zero.
// - Single tx write buffer allows back-to-back frames with no gap.
// - Two-level receive buffer behind the rx shift register.
// - Receiver flags frame error, overrun and parity error.
// - Frame error only from the first stop bit; second one ignored.
module uscg_top
   import uscg_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // register port
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // serial data
   input wire logic RXD_I,
   output logic TXD_O,
   output logic TXD_OE,
   // transfer clock pin
   input wire logic XCK_I,
   output logic XCK_O,
   output logic XCK_OE
);
////////////////////////////////////////////////////////////////////////////////
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];
////////////////////////////////////////////////////////////////////////////////
   logic [7:0] div_low_reg;
   logic [3:0] div_high_reg;
   logic [7:0] ctrl_a_reg;
   logic [7:0] ctrl_b_reg;
   logic [7:0] ctrl_c_reg;
   logic [7:0] pin_ctrl_reg;
   logic [11:0] divisor;
   logic low_wr, data_wr, data_rd;
   logic en, sync_m, master, slave, pol, par_en, par_odd;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         div_low_reg <= DIV_RESET[7:0];
         div_high_reg <= DIV_RESET[11:8];
         ctrl_a_reg <= CTRL_RESET;
         ctrl_b_reg <= CTRL_RESET;
         ctrl_c_reg <= CTRL_RESET;
         pin_ctrl_reg <= CTRL_RESET;
      end else if (WR) begin
         case (ADDR)
            ADDR_DIV_LOW: div_low_reg <= WDATA;
            ADDR_DIV_HIGH: div_high_reg <= WDATA[3:0];
            ADDR_CTRL_A: ctrl_a_reg <= WDATA;
            ADDR_CTRL_B: ctrl_b_reg <= WDATA;
            ADDR_CTRL_C: ctrl_c_reg <= WDATA;
            ADDR_PIN_CTRL: pin_ctrl_reg <= WDATA;
            default: ;
         endcase
      end
   end

   assign divisor = {div_high_reg, div_low_reg};
   assign low_wr = WR && (ADDR == ADDR_DIV_LOW);
   assign data_wr = WR && (ADDR == ADDR_DATA);
   assign data_rd = RD && (ADDR == ADDR_DATA);
   assign en = !pin_ctrl_reg[P_POWER_RED];
   assign sync_m = ctrl_c_reg[C_SYNC];
   assign master = sync_m && pin_ctrl_reg[P_XCK_DIR];
   assign slave = sync_m && !pin_ctrl_reg[P_XCK_DIR];
   assign pol = ctrl_c_reg[C_POL];
   assign par_en = ctrl_c_reg[C_PAR_EN];
   assign par_odd = ctrl_c_reg[C_PAR_ODD];
////////////////////////////////////////////////////////////////////////////////
   // baud generator
   logic [11:0] bd_cnt_reg;
   logic baud_tick;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         bd_cnt_reg <= DIV_RESET;
      end else if (low_wr) begin
         bd_cnt_reg <= {div_high_reg, WDATA};
      end else if (en) begin
         bd_cnt_reg <= (bd_cnt_reg == 12'h000) ? divisor : bd_cnt_reg - 12'h001;
      end
   end
   assign baud_tick = en && (bd_cnt_reg == 12'h000);
////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; s3 only feeds the edge detector
   logic rxd_s1_reg, rxd_s2_reg;
   logic xck_s1_reg, xck_s2_reg, xck_s3_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rxd_s1_reg <= 1'b1;
         rxd_s2_reg <= 1'b1;
         xck_s1_reg <= 1'b0;
         xck_s2_reg <= 1'b0;
         xck_s3_reg <= 1'b0;
      end else begin
         rxd_s1_reg <= RXD_I;
         rxd_s2_reg <= rxd_s1_reg;
         xck_s1_reg <= XCK_I;
         xck_s2_reg <= xck_s1_reg;
         xck_s3_reg <= xck_s2_reg;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // transfer clock: master divides ticks by two, slave detects edges
   logic xck_reg;
   logic xck_rise, xck_fall, change_edge, sample_edge;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         xck_reg <= 1'b0;
      end else if (!master) begin
         xck_reg <= 1'b0;
      end else if (baud_tick) begin
         xck_reg <= !xck_reg;
      end
   end

   always_comb begin
      if (master) begin
         xck_rise = baud_tick && !xck_reg;
         xck_fall = baud_tick && xck_reg;
      end else begin
         xck_rise = en && slave && xck_s2_reg && !xck_s3_reg;
         xck_fall = en && slave && !xck_s2_reg && xck_s3_reg;
      end
   end
   assign change_edge = pol ? xck_fall : xck_rise;
   assign sample_edge = pol ? xck_rise : xck_fall;
////////////////////////////////////////////////////////////////////////////////
   // per-mode sequencer length; double speed ignored in sync mode
   logic [3:0] ph_last, ph_mid;

   always_comb begin
      if (sync_m) begin
         ph_last = PH_LAST_SYNC;
         ph_mid = PH_LAST_SYNC;
      end else if (ctrl_a_reg[A_DOUBLE]) begin
         ph_last = PH_LAST_DOUBLE;
         ph_mid = PH_MID_DOUBLE;
      end else begin
         ph_last = PH_LAST_NORMAL;
         ph_mid = PH_MID_NORMAL;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // transmitter
   logic tx_run;
   logic [3:0] tx_ph_reg;
   logic tx_bit_en, tx_step, tx_load;
   logic [7:0] tx_buf_reg;
   logic tx_full_reg;
   logic [10:0] tx_sh_reg;
   logic [3:0] tx_cnt_reg;
   logic tx_out_reg;
   logic [10:0] tx_frame;
   logic [3:0] tx_len;

   assign tx_run = en && ctrl_b_reg[B_TX_EN];

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         tx_ph_reg <= 4'h0;
      end else if (!tx_run || sync_m) begin
         tx_ph_reg <= 4'h0;
      end else if (baud_tick) begin
         tx_ph_reg <= (tx_ph_reg == ph_last) ? 4'h0 : tx_ph_reg + 4'h1;
      end
   end
   assign tx_bit_en = !sync_m && baud_tick && (tx_ph_reg == ph_last);
   assign tx_step = tx_run && (sync_m ? change_edge : tx_bit_en);
   assign tx_load = tx_step && (tx_cnt_reg == 4'h0) && tx_full_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         tx_buf_reg <= 8'h00;
         tx_full_reg <= 1'b0;
      end else if (data_wr) begin
         tx_buf_reg <= WDATA;
         tx_full_reg <= 1'b1;
      end else if (tx_load) begin
         tx_full_reg <= 1'b0;
      end
   end

   assign tx_frame = par_en ? {2'b11, ^tx_buf_reg ^ par_odd, tx_buf_reg} :
                     {3'b111, tx_buf_reg};
   assign tx_len = TX_BITS_BASE + {3'b000, par_en} + {3'b000, ctrl_c_reg[C_TWO_STOP]};

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_reg <= 11'h7ff;
         tx_cnt_reg <= 4'h0;
         tx_out_reg <= 1'b1;
      end else if (!tx_run) begin
         tx_sh_reg <= 11'h7ff;
         tx_cnt_reg <= 4'h0;
         tx_out_reg <= 1'b1;
      end else if (tx_load) begin
         // next start bit follows the last stop bit directly
         tx_out_reg <= 1'b0;
         tx_sh_reg <= tx_frame;
         tx_cnt_reg <= tx_len;
      end else if (tx_step && tx_cnt_reg != 4'h0) begin
         tx_out_reg <= tx_sh_reg[0];
         tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
         tx_cnt_reg <= tx_cnt_reg - 4'h1;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // receiver
   uscg_rx_e rx_state_reg;
   logic rx_run, rx_samp, rx_done;
   logic [3:0] rx_ph_reg, rx_idx_reg, rx_stop_idx;
   logic [8:0] rx_sh_reg;
   logic [7:0] rx_data;
   uscg_rx_s rx_entry;

   assign rx_run = en && ctrl_b_reg[B_RX_EN];
   assign rx_stop_idx = RX_STOP_BASE + {3'b000, par_en};
   // single mid-bit sample; no majority vote, so noise immunity is reduced
   assign rx_samp = sync_m ? sample_edge : (baud_tick && rx_ph_reg == ph_mid);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_reg <= RX_IDLE;
         rx_ph_reg <= 4'h0;
         rx_idx_reg <= 4'h0;
         rx_sh_reg <= 9'h000;
      end else if (!rx_run) begin
         rx_state_reg <= RX_IDLE;
         rx_ph_reg <= 4'h0;
         rx_idx_reg <= 4'h0;
      end else begin
         case (rx_state_reg)
            RX_IDLE: begin
               rx_ph_reg <= 4'h0;
               rx_idx_reg <= 4'h0;
               if (sync_m) begin
                  if (sample_edge && !rxd_s2_reg) begin
                     rx_state_reg <= RX_BUSY;
                     rx_idx_reg <= 4'h1;
                  end
               end else if (baud_tick && !rxd_s2_reg) begin
                  rx_state_reg <= RX_BUSY;
               end
            end
            RX_BUSY: begin
               if (baud_tick) begin
                  rx_ph_reg <= (rx_ph_reg == ph_last) ? 4'h0 : rx_ph_reg + 4'h1;
               end
               if (rx_samp) begin
                  if (rx_idx_reg == 4'h0 && rxd_s2_reg) begin
                     rx_state_reg <= RX_IDLE;
                  end else if (rx_idx_reg == rx_stop_idx) begin
                     rx_state_reg <= RX_IDLE;
                  end else begin
                     rx_sh_reg <= {rxd_s2_reg, rx_sh_reg[8:1]};
                     rx_idx_reg <= rx_idx_reg + 4'h1;
                  end
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   assign rx_done = rx_run && rx_state_reg == RX_BUSY && rx_samp && rx_idx_reg == rx_stop_idx;
   assign rx_data = par_en ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
   assign rx_entry.data = rx_data;
   assign rx_entry.fe = !rxd_s2_reg;
   assign rx_entry.pe = par_en && (^rx_data ^ par_odd ^ rx_sh_reg[8]);
////////////////////////////////////////////////////////////////////////////////
   // two-level receive buffer
   uscg_rx_s fifo_mem [0:1];
   logic fifo_wp_reg, fifo_rp_reg;
   logic [1:0] fifo_cnt_reg;
   logic pop, push, overrun_reg;
   uscg_rx_s head;

   assign pop = data_rd && fifo_cnt_reg != 2'h0;
   assign push = rx_done && (fifo_cnt_reg != FIFO_FULL || pop);
   assign head = fifo_mem[fifo_rp_reg];

   always_ff @(posedge CLK) begin
      if (push) begin
         fifo_mem[fifo_wp_reg] <= rx_entry;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         fifo_wp_reg <= 1'b0;
         fifo_rp_reg <= 1'b0;
         fifo_cnt_reg <= 2'h0;
      end else begin
         if (push) begin
            fifo_wp_reg <= !fifo_wp_reg;
         end
         if (pop) begin
            fifo_rp_reg <= !fifo_rp_reg;
         end
         fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   // a data read in the cycle a frame completes frees a slot, so the frame is kept and overrun clears
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         overrun_reg <= 1'b0;
      end else if (rx_done && !push) begin
         overrun_reg <= 1'b1;
      end else if (pop) begin
         overrun_reg <= 1'b0;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // read port
   logic [7:0] rdata_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            ADDR_DIV_LOW: rdata_reg <= div_low_reg;
            ADDR_DIV_HIGH: rdata_reg <= {4'h0, div_high_reg};
            ADDR_CTRL_A: rdata_reg <= {fifo_cnt_reg != 2'h0, 1'b0, !tx_full_reg,
                                       head.fe && fifo_cnt_reg != 2'h0, overrun_reg,
                                       head.pe && fifo_cnt_reg != 2'h0,
                                       ctrl_a_reg[A_DOUBLE], 1'b0};
            ADDR_CTRL_B: rdata_reg <= ctrl_b_reg & 8'h18;
            ADDR_CTRL_C: rdata_reg <= ctrl_c_reg & 8'h79;
            ADDR_DATA: rdata_reg <= (fifo_cnt_reg != 2'h0) ? head.data : 8'h00;
            ADDR_PIN_CTRL: rdata_reg <= pin_ctrl_reg & 8'h03;
            default: rdata_reg <= 8'h00;
         endcase
      end
   end

   assign RDATA = rdata_reg;
   assign TXD_O = tx_out_reg;
   assign TXD_OE = tx_run;
   assign XCK_O = xck_reg;
   assign XCK_OE = en && master;
////////////////////////////////////////////////////////////////////////////////
   property p_reload_zero;
      @(posedge CLK) disable iff (!rst_n)
      (baud_tick && !low_wr) |=> bd_cnt_reg == $past(divisor);
   endproperty
   a_reload_zero: assert property (p_reload_zero) else $error("no reload at zero");

   property p_reload_write;
      @(posedge CLK) disable iff (!rst_n)
      low_wr |=> bd_cnt_reg == divisor;
   endproperty
   a_reload_write: assert property (p_reload_write) else $error("no reload on write");

   property p_tx_div;
      @(posedge CLK) disable iff (!rst_n)
      (tx_step && !sync_m) |-> baud_tick && tx_ph_reg == (ctrl_a_reg[A_DOUBLE] ? 4'h7 : 4'hf);
   endproperty
   a_tx_div: assert property (p_tx_div) else $error("tx step off divide");

   property p_master_clk;
      @(posedge CLK) disable iff (!rst_n)
      (master && baud_tick) |=> XCK_O != $past(XCK_O);
   endproperty
   a_master_clk: assert property (p_master_clk) else $error("master clock not toggled");

   property p_pin_unused;
      @(posedge CLK) disable iff (!rst_n)
      (!sync_m || !en) |-> !XCK_OE && !xck_rise && !xck_fall;
   endproperty
   a_pin_unused: assert property (p_pin_unused) else $error("clock pin used in async");

   property p_power_off;
      @(posedge CLK) disable iff (!rst_n)
      !en |-> !TXD_OE && !baud_tick && !rx_done;
   endproperty
   a_power_off: assert property (p_power_off) else $error("active while powered down");

   property p_no_gap;
      @(posedge CLK) disable iff (!rst_n)
      (tx_step && tx_cnt_reg == 4'h0 && tx_full_reg) |=> !TXD_O;
   endproperty
   a_no_gap: assert property (p_no_gap) else $error("gap between frames");

   property p_sync_edge;
      @(posedge CLK) disable iff (!rst_n)
      (sync_m && tx_step) |-> (pol ? xck_fall : xck_rise) && !sample_edge;
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("wrong change edge");

   property p_frame_err;
      @(posedge CLK) disable iff (!rst_n)
      push |=> fifo_mem[$past(fifo_wp_reg)].fe == !$past(rxd_s2_reg);
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("frame error mismatch");

   property p_overrun;
      @(posedge CLK) disable iff (!rst_n)
      (rx_done && fifo_cnt_reg == FIFO_FULL && !pop) |=> overrun_reg && fifo_cnt_reg == FIFO_FULL;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");

   property p_slave_edge;
      @(posedge CLK) disable iff (!rst_n)
      (slave && xck_rise) |-> $past(XCK_I, 2) && !$past(XCK_I, 3);
   endproperty
   a_slave_edge: assert property (p_slave_edge) else $error("slave edge not synced");
endmodule : uscg_top

/* bench/uscg_remote.sv */
/*
 Remote serial party: async sender on the receive line and a slave transfer clock.
 Assumes the bench clock drives it; the line idles high and the clock stands low.
*/
module uscg_remote (
   // bench clock
   input wire logic clk,
   // line side
   output logic line,
   output logic xck
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      line = 1'b1;
      xck = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // start, 8 data lsb first, optional parity, one stop; stop 0 makes a bad frame
   task automatic send(input logic [7:0] d, input int per, input logic pen, pb, sb);
      logic [10:0] f;
      int n;
      f = {sb, pb, d, 1'b0};
      n = pen ? 11 : 10;
      if (!pen) f[9] = sb;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         line <= f[i];
         repeat (per - 1) @(posedge clk);
      end
      @(posedge clk);
      line <= 1'b1;
   endtask : send

   ////////////////////////////////////////////////////////////////////////////////////
   // clock only within frames; half period well above two system clocks
   task automatic run_clock(input int n, half);
      for (int i = 0; i < 2 * n; i++) begin
         repeat (half) @(posedge clk);
         xck <= ~xck;
      end
   endtask : run_clock
endmodule : uscg_remote

/* bench/tb.sv */
/*
 Self-checking bench of the serial transceiver clock front end.
 Assumes uscg_top and uscg_remote are compiled before it.
*/
module tb;
   import uscg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, nrst, wr, rd;
   logic [2:0] addr;
   logic [7:0] wdata, rdata;
   logic txd, txd_oe, xck_o, xck_oe;
   wire logic rxd, xck_part, xck_w;
   int fail_count = 0;
   int checked = 0;
   // address, write data, expected read back
   localparam logic [18:0] ROWS [7] = '{{3'h0, 8'hff, 8'hff}, {3'h1, 8'hff, 8'h0f},
      {3'h2, 8'hff, 8'h22}, {3'h3, 8'h18, 8'h18}, {3'h4, 8'h39, 8'h39},
      {3'h6, 8'h01, 8'h01}, {3'h7, 8'hff, 8'h00}};

   // pin level from whoever drives the transfer clock
   assign xck_w = xck_oe ? xck_o : xck_part;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   uscg_top dut_u (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .RXD_I(rxd), .TXD_O(txd), .TXD_OE(txd_oe), .XCK_I(xck_w),
      .XCK_O(xck_o), .XCK_OE(xck_oe));
   uscg_remote remote_u (.clk(clk), .line(rxd), .xck(xck_part));

   ////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rchk

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // async frame seen at mid-bit; not first means it follows the last stop directly
   task automatic tx_async(input logic [7:0] d, input int per, input logic first);
      logic [9:0] f;
      int n;
      f = {1'b1, d, 1'b0};
      n = 0;
      if (first) begin
         while (txd !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
         end
         repeat (per / 2) @(negedge clk);
      end else repeat (per) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
         if (i > 0) repeat (per) @(negedge clk);
         chk({7'h00, txd}, {7'h00, f[i]});
      end
   endtask : tx_async

   task automatic samp(input logic pol);
      if (pol) @(posedge xck_w);
      else @(negedge xck_w);
   endtask : samp

   task automatic sync_frame(input logic [7:0] d, input logic pol);
      logic [9:0] f;
      int n;
      f = {1'b1, d, 1'b0};
      n = 0;
      do begin
         samp(pol);
         n++;
      end while (txd !== 1'b0 && n < 40);
      for (int i = 0; i < 10; i++) begin
         if (i > 0) samp(pol);
         chk({7'h00, txd}, {7'h00, f[i]});
      end
   endtask : sync_frame

   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      $display("MISMATCH t=%0t run did not finish", $time);
      print_verdict();
   end

   initial begin
      time t0;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      nrst = 1'b0;
      do_reset();
      for (int i = 0; i < 7; i++) begin
         wreg(ROWS[i][18:16], ROWS[i][15:8]);
         rchk(ROWS[i][18:16], ROWS[i][7:0]);
      end
      // second reset mid-run, then reset values
      do_reset();
      for (int i = 0; i < 8; i++) rchk(3'(i), (i == 2) ? 8'h20 : 8'h00);
      // async normal, divisor 1: 32 clocks a bit, back-to-back frames
      wreg(3'h0, 8'h01);
      wreg(3'h3, 8'h18);
      @(negedge clk);
      chk({7'h00, txd_oe}, 8'h01);
      chk({7'h00, xck_oe}, 8'h00);
      wreg(3'h5, 8'ha5);
      fork
         tx_async(8'ha5, 32, 1'b1);
         begin
            repeat (64) @(posedge clk);
            wreg(3'h5, 8'h3c);
         end
      join
      tx_async(8'h3c, 32, 1'b0);
      remote_u.send(8'h96, 32, 1'b0, 1'b0, 1'b1);
      rchk(3'h2, 8'ha0);
      rchk(3'h5, 8'h96);
      // three frames unread: two kept, third overruns
      remote_u.send(8'h11, 32, 1'b0, 1'b0, 1'b1);
      remote_u.send(8'h22, 32, 1'b0, 1'b0, 1'b1);
      remote_u.send(8'h33, 32, 1'b0, 1'b0, 1'b1);
      rchk(3'h2, 8'ha8);
      rchk(3'h5, 8'h11);
      rchk(3'h5, 8'h22);
      rchk(3'h2, 8'h20);
      wreg(3'h4, 8'h20);
      remote_u.send(8'h55, 32, 1'b1, 1'b1, 1'b1);
      rchk(3'h2, 8'ha4);
      rchk(3'h5, 8'h55);
      wreg(3'h4, 8'h30);
      remote_u.send(8'h54, 32, 1'b1, 1'b0, 1'b1);
      rchk(3'h2, 8'ha0);
      rchk(3'h5, 8'h54);
      wreg(3'h4, 8'h08);
      remote_u.send(8'h44, 32, 1'b0, 1'b0, 1'b0);
      rchk(3'h2, 8'hb0);
      rchk(3'h5, 8'h44);
      // double speed: 16 clocks a bit both ways
      do_reset();
      wreg(3'h0, 8'h01);
      wreg(3'h2, 8'h02);
      wreg(3'h3, 8'h18);
      remote_u.send(8'hc7, 16, 1'b0, 1'b0, 1'b1);
      rchk(3'h2, 8'ha2);
      rchk(3'h5, 8'hc7);
      wreg(3'h5, 8'h5a);
      tx_async(8'h5a, 16, 1'b1);
      // sync master, both polarities
      wreg(3'h2, 8'h00);
      wreg(3'h4, 8'h40);
      wreg(3'h6, 8'h01);
      @(negedge clk);
      chk({7'h00, xck_oe}, 8'h01);
      @(posedge xck_o);
      t0 = $time;
      @(posedge xck_o);
      chk(8'(($time - t0) / 10), 8'h04);
      for (int p = 0; p < 2; p++) begin
         wreg(3'h4, 8'h40 | 8'(p));
         wreg(3'h5, 8'hc3 ^ 8'(p));
         sync_frame(8'hc3 ^ 8'(p), 1'(p));
      end
      wreg(3'h6, 8'h03);
      @(negedge clk);
      chk({6'h00, txd_oe, xck_oe}, 8'h00);
      // sync slave: pin clock from the remote party
      wreg(3'h6, 8'h00);
      wreg(3'h4, 8'h40);
      @(negedge clk);
      chk({7'h00, xck_oe}, 8'h00);
      wreg(3'h5, 8'he1);
      fork
         remote_u.run_clock(14, 8);
         sync_frame(8'he1, 1'b0);
      join
      print_verdict();
   end
endmodule : tb
